// >>> logic/lhfe_engine.v
// header and frame engine of the single-wire serial link, with data fifo
// Overview of operation
// [RULE1] slave: line low for 11 bit times at current rate is a break, anytime
// [RULE2] before a break the slave receiver stays idle and drops characters
// [RULE3] break sets break_seen_flag; next character is taken as synch
// [RULE4] synch character other than 0x55 sets synch_mismatch_error_flag
// [RULE5] identifier received: set ident_received_flag, load identifier field
// [RULE6] header flags stay set until clear_status_bit is pulsed
// [RULE7] baud measured only in slave role, between synch falling edges
// [RULE8] 19-bit counter cleared at synch start, counts 8 bit times, stops
// [RULE9] counter upper 16 bits give divider, lower 3 bits the fraction
// [RULE10] after synch the baud divider and fraction take measured values
// [RULE11] protected identifier: bits 0..5 identifier, bits 6..7 parity
// [RULE12] parity on: send low 6 identifier bits plus computed parity
// [RULE13] parity on: check parity on receive, store low 6 bits, top zero
// [RULE14] parity off: send and store all eight identifier bits unchanged
// [RULE15] node action picks publish, subscribe or ignore for the response
// [RULE16] user length mode: length code plus one data bytes, 1 to 256
// [RULE17] identifier length mode: bits 5:4 give 2, 2, 4 or 8 bytes
// [RULE18] checksum is inverted carry-wrapped sum; enhanced adds identifier
// [RULE19] checksum on: type 0 enhanced, type 1 classic; off: none
// [RULE20] master slot mode: transmit ready returns after max frame time
// [RULE21] with checksum max frame time is 77 plus 14 times code bits
// [RULE22] without checksum max frame time is 63 plus 14 times code bits
// [RULE23] mode 0xA selects master role, 0xB selects slave role
// [RULE24] master header: 13 dominant bits, 1 recessive, 0x55, identifier
// [RULE25] parity 6 is xor of id 0,1,2,4; parity 7 inverted xor of 1,3,4,5
`include "lhfe_map.vh"

module lhfe_fifo #(
	parameter W  = 8,
	parameter D  = 4,
	parameter AW = 2
) (
	input  wire          clk,
	input  wire          clk_en,
	input  wire          nrst,
	input  wire          in_valid,
	input  wire [W-1:0]  in_data,
	output wire          in_ready,
	output wire          out_valid,
	output wire [W-1:0]  out_data,
	input  wire          out_ready
);
	localparam [AW:0] DEPTH_C = D[AW:0];
	reg  [W-1:0]  mem [0:D-1];
	reg  [AW-1:0] wr_q;
	reg  [AW-1:0] rd_q;
	reg  [AW:0]   cnt_q;
	reg           rdy_q;
	wire          push  = in_valid & rdy_q;
	wire          pull  = out_ready & (cnt_q != {(AW+1){1'b0}});
	wire [AW:0]   cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pull};

	assign in_ready  = rdy_q;
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data  = mem[rd_q];

	always @(posedge clk) begin
		if (!nrst) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			rdy_q <= 1'b1;
		end else if (clk_en) begin
			if (push) begin
				mem[wr_q] <= in_data;
				wr_q      <= wr_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pull)
				rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
			cnt_q <= cnt_d;
			rdy_q <= (cnt_d != DEPTH_C);
		end
	end
endmodule

module lhfe_engine (
	input  wire        clk,
	input  wire        clk_en,
	input  wire        nrst,
	input  wire [3:0]  mode,
	input  wire [1:0]  node_action_field,
	input  wire        parity_disable_bit,
	input  wire        checksum_disable_bit,
	input  wire        checksum_type_bit,
	input  wire        length_mode_bit,
	input  wire        frame_slot_disable_bit,
	input  wire [7:0]  length_code_field,
	input  wire        ident_wr,
	input  wire [7:0]  ident_wdata,
	input  wire        baud_wr,
	input  wire [15:0] baud_wdata_div,
	input  wire [2:0]  baud_wdata_frac,
	input  wire        clear_status_bit,
	input  wire        tx_in_valid,
	input  wire [7:0]  tx_in_data,
	output wire        tx_in_ready,
	input  wire        lin_rx,
	output wire        lin_tx,
	output wire [7:0]  ident_character_field,
	output wire [15:0] baud_divider_field,
	output wire [2:0]  baud_fraction_field,
	output wire        break_seen_flag,
	output wire        ident_received_flag,
	output wire        synch_mismatch_error_flag,
	output wire        ident_parity_error_flag,
	output wire        checksum_error_flag,
	output wire        frame_done_flag,
	output wire        transmit_ready_flag,
	output wire        rx_valid,
	output wire [7:0]  rx_data
);
	localparam [9:0] ST_IDLE  = 10'h001;
	localparam [9:0] ST_MBRK  = 10'h002;
	localparam [9:0] ST_MSYNC = 10'h004;
	localparam [9:0] ST_MID   = 10'h008;
	localparam [9:0] ST_SDLM  = 10'h010;
	localparam [9:0] ST_SSYNC = 10'h020;
	localparam [9:0] ST_SID   = 10'h040;
	localparam [9:0] ST_RESP  = 10'h080;
	localparam [9:0] ST_CHK   = 10'h100;
	localparam [9:0] ST_SLOT  = 10'h200;

	function [1:0] lhfe_par;
		input [5:0] i;
		begin
			lhfe_par = {~(i[1] ^ i[3] ^ i[4] ^ i[5]),
				i[0] ^ i[1] ^ i[2] ^ i[4]}; // [RULE25]
		end
	endfunction

	function [7:0] lhfe_csum;
		input [7:0] s;
		input [7:0] b;
		reg   [8:0] t;
		begin
			t = {1'b0, s} + {1'b0, b};
			lhfe_csum = t[7:0] + {7'h00, t[8]}; // [RULE18]
		end
	endfunction

	function [13:0] lhfe_char;
		input [7:0] d;
		begin
			lhfe_char = {4'hF, 1'b1, d, 1'b0};
		end
	endfunction

	reg  [9:0]  st_q;
	reg  [9:0]  st_d;
	reg  [7:0]  ident_q;
	reg  [7:0]  id_nx;
	reg  [15:0] div_q;
	reg  [2:0]  frac_q;
	reg         brk_f_q;
	reg         idr_f_q;
	reg         sme_f_q;
	reg         ipe_f_q;
	reg         cke_f_q;
	reg         fin_f_q;
	reg         transmit_ready_flag_q;
	reg         rxv_q;
	reg  [7:0]  rxd_q;
	reg         lin_tx_q;
	reg         rx_prev_q;
	reg  [19:0] low_cyc_q;
	reg         rx_busy_q;
	reg  [15:0] rx_tmr_q;
	reg  [3:0]  rx_cnt_q;
	reg  [7:0]  rx_sh_q;
	reg         rx_done_q;
	reg  [7:0]  rx_byte_q;
	reg         tx_busy_q;
	reg         tx_done_q;
	reg  [15:0] tx_tmr_q;
	reg  [3:0]  tx_cnt_q;
	reg  [13:0] tx_sh_q;
	reg  [18:0] meas_q;
	reg         meas_run_q;
	reg         meas_ok_q;
	reg  [1:0]  fe_q;
	reg  [8:0]  cnt_q;
	reg  [7:0]  sum_q;
	reg  [15:0] slot_tmr_q;
	reg  [11:0] slot_bits_q;
	reg         tx_ld;
	reg  [13:0] tx_ld_val;
	reg  [3:0]  tx_ld_len;
	reg         tx_pop;
	reg         fin;
	wire        f_valid;
	wire [7:0]  f_data;

	wire is_master = (mode == `LHFE_MODE_MASTER); // [RULE23]
	wire is_slave  = (mode == `LHFE_MODE_SLAVE);  // [RULE23]
	wire [15:0] bl = (div_q == 16'h0000) ? 16'h0001 : div_q;
	wire [15:0] bl_m1 = bl - 16'h0001;
	wire [19:0] brk_thr = `LHFE_BRK_DET_BITS * {4'h0, bl};
	wire brk_hit = is_slave & ~lin_rx &
		(low_cyc_q == brk_thr - 20'h00001); // [RULE1]
	wire fe_now = rx_prev_q & ~lin_rx;
	wire chk_on = ~checksum_disable_bit;
	wire publ = (node_action_field == `LHFE_NODE_ACTION_FIELD_PUBLISH);
	wire subs = (node_action_field == `LHFE_NODE_ACTION_FIELD_SUBSCR);
	wire [7:0] pid = parity_disable_bit ? ident_q :
		{lhfe_par(ident_q[5:0]), ident_q[5:0]}; // [RULE12] [RULE14]
	wire [7:0] pid_nx = parity_disable_bit ? id_nx :
		{lhfe_par(id_nx[5:0]), id_nx[5:0]}; // [RULE11]
	wire [8:0] n_bytes = length_mode_bit ?
		(ident_q[5] ? (ident_q[4] ? 9'h008 : 9'h004) : 9'h002) :
		({1'b0, length_code_field} + 9'h001); // [RULE16] [RULE17]
	wire [11:0] tfmax = (chk_on ? `LHFE_TF_CHK : `LHFE_TF_NOCHK) +
		`LHFE_TF_PER_CODE * {4'h0, length_code_field}; // [RULE21] [RULE22]
	wire rx_en = (st_q == ST_SSYNC) | (st_q == ST_SID) |
		(((st_q == ST_RESP) | (st_q == ST_CHK)) & subs); // [RULE2]
	wire hdr_go = is_master & ident_wr & transmit_ready_flag_q & (st_q == ST_IDLE);
	wire rx_got = (st_q == ST_RESP) & subs & rx_done_q & (cnt_q != n_bytes);

	assign lin_tx                    = lin_tx_q;
	assign ident_character_field     = ident_q;
	assign baud_divider_field        = div_q;
	assign baud_fraction_field       = frac_q;
	assign break_seen_flag           = brk_f_q;
	assign ident_received_flag       = idr_f_q;
	assign synch_mismatch_error_flag = sme_f_q;
	assign ident_parity_error_flag   = ipe_f_q;
	assign checksum_error_flag       = cke_f_q;
	assign frame_done_flag           = fin_f_q;
	assign transmit_ready_flag       = transmit_ready_flag_q;
	assign rx_valid                  = rxv_q;
	assign rx_data                   = rxd_q;

	lhfe_fifo #(.W(8), .D(4), .AW(2)) u_fifo (
		.clk       (clk),
		.clk_en    (clk_en),
		.nrst      (nrst),
		.in_valid  (tx_in_valid),
		.in_data   (tx_in_data),
		.in_ready  (tx_in_ready),
		.out_valid (f_valid),
		.out_data  (f_data),
		.out_ready (tx_pop)
	);

	always @* begin
		id_nx = ident_q;
		if (hdr_go)
			id_nx = ident_wdata;
		else if ((st_q == ST_SID) & rx_done_q)
			id_nx = parity_disable_bit ? rx_byte_q :
				{2'b00, rx_byte_q[5:0]}; // [RULE13] [RULE14] [RULE5]
	end

	always @* begin
		st_d      = st_q;
		tx_ld     = 1'b0;
		tx_ld_val = 14'h3FFF;
		tx_ld_len = 4'h0;
		tx_pop    = 1'b0;
		fin       = 1'b0;
		case (st_q)
		ST_IDLE: begin
			if (hdr_go) begin
				st_d      = ST_MBRK;
				tx_ld     = 1'b1;
				tx_ld_val = `LHFE_BRK_PATTERN; // [RULE24]
				tx_ld_len = `LHFE_BRK_LEN;
			end
		end
		ST_MBRK: begin
			if (tx_done_q) begin
				st_d      = ST_MSYNC;
				tx_ld     = 1'b1;
				tx_ld_val = lhfe_char(`LHFE_SYNCH_CHAR); // [RULE24]
				tx_ld_len = `LHFE_CHAR_LEN;
			end
		end
		ST_MSYNC: begin
			if (tx_done_q) begin
				st_d      = ST_MID;
				tx_ld     = 1'b1;
				tx_ld_val = lhfe_char(pid); // [RULE12] [RULE14]
				tx_ld_len = `LHFE_CHAR_LEN;
			end
		end
		ST_MID: begin
			if (tx_done_q)
				st_d = ST_RESP;
		end
		ST_SDLM: begin
			if (lin_rx)
				st_d = ST_SSYNC; // [RULE3]
		end
		ST_SSYNC: begin
			if (rx_done_q)
				st_d = ST_SID;
		end
		ST_SID: begin
			if (rx_done_q)
				st_d = ST_RESP;
		end
		ST_RESP: begin
			if (publ) begin // [RULE15]
				if (cnt_q == n_bytes) begin
					if (!tx_busy_q) begin
						if (chk_on) begin // [RULE19]
							st_d      = ST_CHK;
							tx_ld     = 1'b1;
							tx_ld_val = lhfe_char(~sum_q);
							tx_ld_len = `LHFE_CHAR_LEN;
						end else begin
							fin = 1'b1;
						end
					end
				end else if (!tx_busy_q && f_valid) begin
					tx_ld     = 1'b1;
					tx_ld_val = lhfe_char(f_data);
					tx_ld_len = `LHFE_CHAR_LEN;
					tx_pop    = 1'b1;
				end
			end else if (subs) begin
				if (cnt_q == n_bytes) begin
					if (chk_on)
						st_d = ST_CHK; // [RULE19]
					else
						fin = 1'b1;
				end
			end else begin
				fin = 1'b1; // [RULE15]
			end
		end
		ST_CHK: begin
			if (publ ? tx_done_q : rx_done_q)
				fin = 1'b1;
		end
		ST_SLOT: begin
			if (slot_bits_q >= tfmax)
				st_d = ST_IDLE; // [RULE20]
		end
		default: begin
			st_d = ST_IDLE;
		end
		endcase
		if (fin)
			st_d = (is_master & ~frame_slot_disable_bit) ?
				ST_SLOT : ST_IDLE; // [RULE20]
		if (brk_hit) begin
			st_d  = ST_SDLM; // [RULE1] [RULE3]
			tx_ld = 1'b0;
		end
	end

	always @(posedge clk) begin
		if (!nrst) begin
			st_q        <= ST_IDLE;
			ident_q     <= 8'h00;
			div_q       <= `LHFE_DIV_RST;
			frac_q      <= `LHFE_FRAC_RST;
			brk_f_q     <= 1'b0;
			idr_f_q     <= 1'b0;
			sme_f_q     <= 1'b0;
			ipe_f_q     <= 1'b0;
			cke_f_q     <= 1'b0;
			fin_f_q     <= 1'b0;
			transmit_ready_flag_q     <= 1'b1;
			rxv_q       <= 1'b0;
			rxd_q       <= 8'h00;
			lin_tx_q    <= 1'b1;
			rx_prev_q   <= 1'b1;
			low_cyc_q   <= 20'h00000;
			rx_busy_q   <= 1'b0;
			rx_tmr_q    <= 16'h0000;
			rx_cnt_q    <= 4'h0;
			rx_sh_q     <= 8'h00;
			rx_done_q   <= 1'b0;
			rx_byte_q   <= 8'h00;
			tx_busy_q   <= 1'b0;
			tx_done_q   <= 1'b0;
			tx_tmr_q    <= 16'h0000;
			tx_cnt_q    <= 4'h0;
			tx_sh_q     <= 14'h3FFF;
			meas_q      <= 19'h00000;
			meas_run_q  <= 1'b0;
			meas_ok_q   <= 1'b0;
			fe_q        <= 2'h0;
			cnt_q       <= 9'h000;
			sum_q       <= 8'h00;
			slot_tmr_q  <= 16'h0000;
			slot_bits_q <= 12'h000;
		end else if (clk_en) begin
			st_q      <= st_d;
			ident_q   <= id_nx; // [RULE5]
			rx_prev_q <= lin_rx;
			rxv_q     <= rx_got;
			if (rx_got)
				rxd_q <= rx_byte_q;
			// sticky flags: a set in the clearing cycle survives
			brk_f_q <= brk_hit |
				((st_q == ST_MBRK) & tx_done_q) |
				(brk_f_q & ~clear_status_bit); // [RULE3] [RULE6]
			idr_f_q <= ((st_q == ST_SID) & rx_done_q) |
				((st_q == ST_MID) & tx_done_q) |
				(idr_f_q & ~clear_status_bit); // [RULE5] [RULE6]
			sme_f_q <= ((st_q == ST_SSYNC) & rx_done_q &
				(rx_byte_q != `LHFE_SYNCH_CHAR)) |
				(sme_f_q & ~clear_status_bit); // [RULE4] [RULE6]
			ipe_f_q <= ((st_q == ST_SID) & rx_done_q &
				~parity_disable_bit &
				(lhfe_par(rx_byte_q[5:0]) != rx_byte_q[7:6])) |
				(ipe_f_q & ~clear_status_bit); // [RULE13]
			cke_f_q <= ((st_q == ST_CHK) & subs & rx_done_q &
				(rx_byte_q != ~sum_q)) |
				(cke_f_q & ~clear_status_bit); // [RULE18] [RULE19]
			fin_f_q <= fin | (fin_f_q & ~clear_status_bit);
			if (hdr_go)
				transmit_ready_flag_q <= 1'b0;
			else if ((st_d == ST_IDLE) && (st_q != ST_IDLE))
				transmit_ready_flag_q <= 1'b1; // [RULE20]
			// hardware update of the rate wins over a software write
			if ((st_q == ST_SSYNC) && rx_done_q && meas_ok_q) begin
				div_q  <= meas_q[18:3]; // [RULE9] [RULE10]
				frac_q <= meas_q[2:0];  // [RULE9] [RULE10]
			end else if (baud_wr) begin
				div_q  <= baud_wdata_div;
				frac_q <= baud_wdata_frac;
			end
			if (lin_rx)
				low_cyc_q <= 20'h00000;
			else if (low_cyc_q != 20'hFFFFF)
				low_cyc_q <= low_cyc_q + 20'h00001;
			// character receiver, centre-sampled
			rx_done_q <= 1'b0;
			if (brk_hit || !rx_en) begin
				rx_busy_q <= 1'b0; // [RULE2]
			end else if (!rx_busy_q) begin
				if (fe_now) begin
					rx_busy_q <= 1'b1;
					rx_tmr_q  <= {1'b0, bl[15:1]};
					rx_cnt_q  <= 4'h0;
				end
			end else if (rx_tmr_q != 16'h0000) begin
				rx_tmr_q <= rx_tmr_q - 16'h0001;
			end else begin
				rx_tmr_q <= bl_m1;
				rx_cnt_q <= rx_cnt_q + 4'h1;
				if (rx_cnt_q == 4'h0) begin
					if (lin_rx)
						rx_busy_q <= 1'b0;
				end else if (rx_cnt_q == 4'h9) begin
					rx_busy_q <= 1'b0;
					rx_done_q <= 1'b1;
					rx_byte_q <= rx_sh_q;
				end else begin
					rx_sh_q <= {lin_rx, rx_sh_q[7:1]};
				end
			end
			// character and break transmitter
			tx_done_q <= 1'b0;
			lin_tx_q  <= tx_busy_q ? tx_sh_q[0] : 1'b1;
			if (tx_ld) begin
				tx_sh_q   <= tx_ld_val;
				tx_cnt_q  <= tx_ld_len;
				tx_tmr_q  <= bl_m1;
				tx_busy_q <= 1'b1;
			end else if (tx_busy_q) begin
				if (tx_tmr_q != 16'h0000) begin
					tx_tmr_q <= tx_tmr_q - 16'h0001;
				end else begin
					tx_tmr_q <= bl_m1;
					tx_sh_q  <= {1'b1, tx_sh_q[13:1]};
					tx_cnt_q <= tx_cnt_q - 4'h1;
					if (tx_cnt_q == 4'h1) begin
						tx_busy_q <= 1'b0;
						tx_done_q <= 1'b1;
					end
				end
			end
			// synch timing between falling edges
			if ((st_q != ST_SSYNC) || !is_slave) begin
				meas_run_q <= 1'b0; // [RULE7]
				meas_ok_q  <= 1'b0;
			end else if (!meas_run_q && !meas_ok_q && fe_now) begin
				meas_q     <= 19'h00000; // [RULE8]
				meas_run_q <= 1'b1;
				fe_q       <= 2'h0;
			end else if (meas_run_q) begin
				meas_q <= meas_q + 19'h00001; // [RULE8]
				if (fe_now) begin
					fe_q <= fe_q + 2'h1;
					if (fe_q == `LHFE_SYNC_EDGES) begin
						meas_run_q <= 1'b0; // [RULE8]
						meas_ok_q  <= 1'b1;
					end
				end
			end
			// response byte count and running checksum
			if ((st_d == ST_RESP) && (st_q != ST_RESP)) begin
				cnt_q <= 9'h000;
				sum_q <= checksum_type_bit ? 8'h00 : pid_nx; // [RULE19]
			end else if (tx_pop || rx_got) begin
				cnt_q <= cnt_q + 9'h001;
				sum_q <= lhfe_csum(sum_q,
					tx_pop ? f_data : rx_byte_q); // [RULE18]
			end
			// frame slot time in bit periods from frame start
			if (hdr_go) begin
				slot_tmr_q  <= bl_m1;
				slot_bits_q <= 12'h000;
			end else if (slot_bits_q != 12'hFFF) begin
				if (slot_tmr_q != 16'h0000) begin
					slot_tmr_q <= slot_tmr_q - 16'h0001;
				end else begin
					slot_tmr_q  <= bl_m1;
					slot_bits_q <= slot_bits_q + 12'h001;
				end
			end
		end
	end
endmodule

// >>> logic/lhfe_map.vh
// constants of the header and frame engine
`ifndef LHFE_MAP_VH
`define LHFE_MAP_VH
`define LHFE_MODE_MASTER   4'hA
`define LHFE_MODE_SLAVE    4'hB
`define LHFE_SYNCH_CHAR    8'h55
`define LHFE_BRK_PATTERN   14'h2000
`define LHFE_BRK_LEN       4'hE
`define LHFE_CHAR_LEN      4'hA
`define LHFE_BRK_DET_BITS  20'h0000B
`define LHFE_NODE_ACTION_FIELD_PUBLISH  2'h0
`define LHFE_NODE_ACTION_FIELD_SUBSCR   2'h1
`define LHFE_NODE_ACTION_FIELD_IGNORE   2'h2
`define LHFE_TF_CHK        12'h04D
`define LHFE_TF_NOCHK      12'h03F
`define LHFE_TF_PER_CODE   12'h00E
`define LHFE_SYNC_EDGES    2'h3
`define LHFE_DIV_RST       16'h0010
`define LHFE_FRAC_RST      3'h0
`endif

// >>> testbench/lhfe_engine_sva.sv
// port assertions of the header and frame engine
`include "lhfe_map.vh"
module lhfe_engine_sva (
	input wire logic        clk,
	input wire logic        clk_en,
	input wire logic        nrst,
	input wire logic [3:0]  mode,
	input wire logic        parity_disable_bit,
	input wire logic        checksum_disable_bit,
	input wire logic        frame_slot_disable_bit,
	input wire logic [7:0]  length_code_field,
	input wire logic        ident_wr,
	input wire logic        baud_wr,
	input wire logic        clear_status_bit,
	input wire logic        lin_rx,
	input wire logic        lin_tx,
	input wire logic [7:0]  ident_character_field,
	input wire logic [15:0] baud_divider_field,
	input wire logic        break_seen_flag,
	input wire logic        ident_received_flag,
	input wire logic        synch_mismatch_error_flag,
	input wire logic        ident_parity_error_flag,
	input wire logic        transmit_ready_flag
);
	logic [19:0] low_q;
	logic [19:0] cyc_q;
	logic [35:0] lim_w;
	logic        take_w;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	assign take_w = ident_wr && mode == `LHFE_MODE_MASTER
		&& transmit_ready_flag;
	assign lim_w = ((checksum_disable_bit ? 36'h3F : 36'h4D)
		+ 36'hE * length_code_field) * baud_divider_field;
	// run length of a low bus, and cycles since the header was taken
	always @(posedge clk) begin
		if (!nrst || lin_rx)
			low_q <= 20'h00000;
		else if (clk_en && low_q != 20'hFFFFF)
			low_q <= low_q + 20'h00001;
		if (!nrst || take_w)
			cyc_q <= 20'h00000;
		else if (cyc_q != 20'hFFFFF)
			cyc_q <= cyc_q + 20'h00001;
	end
	sequence hdr_break_s;
		!transmit_ready_flag ##[1:2] (!lin_tx) [*8];
	endsequence
	hdr_start_a: assert property (take_w |=> hdr_break_s)
		else $error("header did not open with a low break");
	brk_detect_a: assert property (mode == `LHFE_MODE_SLAVE
		&& low_q == 20'hB * baud_divider_field |-> ##[0:2] break_seen_flag)
		else $error("long low bus not taken as a break");
	brk_first_a: assert property ($rose(ident_received_flag)
		|-> break_seen_flag)
		else $error("identifier taken without a break");
	flags_hold_a: assert property (($fell(break_seen_flag)
		|| $fell(ident_received_flag) || $fell(synch_mismatch_error_flag))
		|-> $past(clear_status_bit))
		else $error("header flag dropped without a clear");
	flags_clear_a: assert property (clear_status_bit && !ident_wr
		|=> !break_seen_flag && !ident_received_flag)
		else $error("clear left header flags set");
	div_source_a: assert property ($changed(baud_divider_field)
		|-> $past(baud_wr)
		|| ($past(mode) == `LHFE_MODE_SLAVE && break_seen_flag))
		else $error("divider changed outside synch or write");
	id_top_zero_a: assert property ($rose(ident_received_flag)
		&& mode == `LHFE_MODE_SLAVE && !parity_disable_bit
		|-> ident_character_field[7:6] == 2'h0)
		else $error("stored identifier keeps parity bits");
	par_off_a: assert property ($rose(ident_parity_error_flag)
		|-> !parity_disable_bit)
		else $error("parity error with parity off");
	slot_wait_a: assert property ($rose(transmit_ready_flag)
		&& mode == `LHFE_MODE_MASTER && !frame_slot_disable_bit
		|-> {16'h0000, cyc_q} + 36'h2 >= lim_w)
		else $error("transmit ready before the frame slot ended");
endmodule

bind lhfe_engine lhfe_engine_sva lhfe_engine_sva_i (.*);

// >>> testbench/lhfe_bus_node.sv
// far bus node: sends break, characters and headers, collects bus chars
module lhfe_bus_node (
	input  wire logic clk,
	input  wire logic bus,
	output logic      drive
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_q [$];
	int         rx_bit = 16;
	logic [7:0] v;
	initial drive = 1'b1;
	task automatic send_bits(input logic lvl, input int n);
		drive = lvl;
		repeat (n) @(negedge clk);
	endtask
	task automatic send_char(input logic [7:0] c, input int tb);
		logic [9:0] f;
		f = {1'b1, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			drive = f[i];
			repeat (tb) @(negedge clk);
		end
	endtask
	// break of 13 low bits, one high bit, synch, protected identifier
	task automatic send_header(input logic [7:0] syn, idb, input int tb);
		send_bits(1'b0, 13 * tb);
		send_bits(1'b1, tb);
		send_char(syn, tb);
		send_char(idb, tb);
	endtask
	// lsb-first receiver sampling mid-bit at rx_bit cycles a bit
	initial forever begin
		@(negedge clk iff bus === 1'b0);
		repeat (rx_bit / 2) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (rx_bit) @(negedge clk);
			v[i] = bus;
		end
		wait (bus === 1'b1);
		rx_q.push_back(v);
	end
endmodule

// >>> testbench/tb_lhfe_engine.sv
// self-checking bench of the header and frame engine
`include "lhfe_map.vh"
module tb_lhfe_engine;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk;
	logic        clk_en;
	logic        nrst;
	logic [3:0]  mode;
	logic [1:0]  node_action_field;
	logic        parity_disable_bit;
	logic        checksum_disable_bit;
	logic        checksum_type_bit;
	logic        length_mode_bit;
	logic        frame_slot_disable_bit;
	logic [7:0]  length_code_field;
	logic        ident_wr;
	logic [7:0]  ident_wdata;
	logic        baud_wr;
	logic [15:0] baud_wdata_div;
	logic [2:0]  baud_wdata_frac;
	logic        clear_status_bit;
	logic        tx_in_valid;
	logic [7:0]  tx_in_data;
	wire         tx_in_ready;
	wire         lin_rx;
	wire         lin_tx;
	wire         drv;
	wire  [7:0]  ident_character_field;
	wire  [15:0] baud_divider_field;
	wire  [2:0]  baud_fraction_field;
	wire         break_seen_flag;
	wire         ident_received_flag;
	wire         synch_mismatch_error_flag;
	wire         ident_parity_error_flag;
	wire         checksum_error_flag;
	wire         frame_done_flag;
	wire         transmit_ready_flag;
	wire         rx_valid;
	wire  [7:0]  rx_data;
	int          failures;
	int          compares;
	int          n;
	logic [7:0]  got_q [$];
	logic [7:0]  dq [$];
	logic [7:0]  cs;
	logic [3:0]  f;
	logic [7:0]  c_id [6] = '{8'h12, 8'h12, 8'h02, 8'h30, 8'h20, 8'h10};
	logic [3:0]  c_f [6] = '{4'h0, 4'h2, 4'hC, 4'hB, 4'h8, 4'h8};
	// wired-and bus, low wins
	assign lin_rx = drv & lin_tx;
	lhfe_engine lhfe_engine_i (.*);
	lhfe_bus_node lhfe_bus_node_i (.clk(clk), .bus(lin_rx), .drive(drv));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(negedge clk)
		if (rx_valid === 1'b1)
			got_q.push_back(rx_data);
	task automatic chk(input string nm, input logic [35:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic clr;
		clear_status_bit = 1'b1;
		cyc(1);
		clear_status_bit = 1'b0;
	endtask
	function automatic logic [7:0] pid(input logic [7:0] i);
		return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4],
			i[5:0]};
	endfunction
	function automatic logic [7:0] csum(input logic [7:0] s0,
		input logic [7:0] d[$]);
		logic [8:0] s;
		s = {1'b0, s0};
		foreach (d[i]) begin
			s = s + d[i];
			if (s[8])
				s = s - 9'h0FF;
		end
		return ~s[7:0];
	endfunction
	task automatic hdr(input logic [7:0] syn, idb);
		// far master 17 cycles a bit, inside the receiver's rate tolerance
		lhfe_bus_node_i.send_header(syn, idb, 17);
		cyc(40);
	endtask
	task automatic mframe(input logic [7:0] i, input logic [1:0] a,
		input logic cd, fs, input logic [7:0] lc);
		node_action_field = a;
		checksum_disable_bit = cd;
		frame_slot_disable_bit = fs;
		length_code_field = lc;
		lhfe_bus_node_i.rx_q.delete();
		ident_wdata = i;
		ident_wr = 1'b1;
		cyc(1);
		ident_wr = 1'b0;
		n = 1;
		while (transmit_ready_flag !== 1'b1 && n < 6000) begin
			cyc(1);
			n++;
		end
		cyc(40);
	endtask
	task automatic chk_bus;
		chk("bus_count", lhfe_bus_node_i.rx_q.size(), dq.size());
		foreach (dq[i])
			chk("bus_char", lhfe_bus_node_i.rx_q[i], dq[i]);
	endtask
	initial begin
		#250000;
		failures++;
		summarize;
	end
	initial begin
		clk_en = 1'b1;
		nrst = 1'b0;
		mode = 4'h0;
		node_action_field = `LHFE_NODE_ACTION_FIELD_IGNORE;
		{parity_disable_bit, checksum_disable_bit, checksum_type_bit} = 3'h0;
		{length_mode_bit, frame_slot_disable_bit, ident_wr, baud_wr} = 4'h0;
		{clear_status_bit, tx_in_valid} = 2'h0;
		length_code_field = 8'h02;
		ident_wdata = 8'h00;
		baud_wdata_div = 16'h0010;
		baud_wdata_frac = 3'h0;
		tx_in_data = 8'h00;
		failures = 0;
		compares = 0;
		cyc(16);
		nrst = 1'b1;
		lhfe_bus_node_i.send_bits(1'b0, 400);
		lhfe_bus_node_i.send_bits(1'b1, 20);
		chk("brk_no_role", break_seen_flag, 1'b0);
		mode = `LHFE_MODE_SLAVE;
		lhfe_bus_node_i.send_char(`LHFE_SYNCH_CHAR, 16);
		lhfe_bus_node_i.send_char(pid(8'h3C), 16);
		cyc(20);
		chk("id_no_brk", ident_received_flag, 1'b0);
		hdr(`LHFE_SYNCH_CHAR, pid(8'h3C));
		chk("brk", break_seen_flag, 1'b1);
		chk("id_flag", ident_received_flag, 1'b1);
		chk("ident", ident_character_field, 8'h3C);
		chk("par_ok", ident_parity_error_flag, 1'b0);
		chk("syn_ok", synch_mismatch_error_flag, 1'b0);
		chk("div", baud_divider_field, 16'h0011);
		chk("frac", baud_fraction_field, 3'h0);
		clr();
		chk("flags_clr", {break_seen_flag, ident_received_flag}, 2'h0);
		hdr(`LHFE_SYNCH_CHAR, pid(8'h3C) ^ 8'h80);
		chk("par_bad", ident_parity_error_flag, 1'b1);
		chk("ident_low6", ident_character_field, 8'h3C);
		clr();
		parity_disable_bit = 1'b1;
		hdr(`LHFE_SYNCH_CHAR, 8'hC5);
		chk("ident_raw", ident_character_field, 8'hC5);
		chk("par_off", ident_parity_error_flag, 1'b0);
		parity_disable_bit = 1'b0;
		clr();
		node_action_field = `LHFE_NODE_ACTION_FIELD_SUBSCR;
		for (int k = 0; k < 6; k++) begin
			f = c_f[k];
			{length_mode_bit, checksum_disable_bit, checksum_type_bit} = f[3:1];
			n = !f[3] ? 3 : c_id[k][5:4] == 2'h3 ? 8 : c_id[k][5] ? 4 : 2;
			dq.delete();
			got_q.delete();
			for (int i = 0; i < n; i++)
				dq.push_back(8'(8'h80 + i * 37 + k));
			cs = csum(f[1] ? 8'h00 : pid(c_id[k]), dq);
			lhfe_bus_node_i.send_header(`LHFE_SYNCH_CHAR, pid(c_id[k]), 17);
			foreach (dq[i])
				lhfe_bus_node_i.send_char(dq[i], 17);
			if (!f[2])
				lhfe_bus_node_i.send_char(cs ^ {7'h00, f[0]}, 17);
			cyc(60);
			chk("rx_count", got_q.size(), n);
			foreach (dq[i])
				chk("rx_byte", got_q[i], dq[i]);
			chk("cks_err", checksum_error_flag, f[0]);
			chk("done", frame_done_flag, 1'b1);
			clr();
		end
		node_action_field = `LHFE_NODE_ACTION_FIELD_IGNORE;
		length_mode_bit = 1'b0;
		hdr(8'h15, pid(8'h3C));
		cyc(200);
		chk("syn_bad", synch_mismatch_error_flag, 1'b1);
		mode = `LHFE_MODE_MASTER;
		baud_wr = 1'b1;
		cyc(1);
		baud_wr = 1'b0;
		clr();
		tx_in_valid = 1'b1;
		for (int i = 0; i < 5; i++) begin
			tx_in_data = 8'(8'h31 + i);
			cyc(1);
		end
		tx_in_valid = 1'b0;
		chk("fifo_full", tx_in_ready, 1'b0);
		mframe(8'hFC, `LHFE_NODE_ACTION_FIELD_PUBLISH, 1'b0, 1'b0, 8'h03);
		chk("slot_chk", n >= 1902 && n <= 1907, 1'b1);
		dq = '{8'h31, 8'h32, 8'h33, 8'h34};
		cs = csum(pid(8'h3C), dq);
		dq = '{8'h00, `LHFE_SYNCH_CHAR, pid(8'h3C), 8'h31, 8'h32, 8'h33,
			8'h34, cs};
		chk_bus();
		chk("fifo_empty", tx_in_ready, 1'b1);
		parity_disable_bit = 1'b1;
		mframe(8'hC5, `LHFE_NODE_ACTION_FIELD_IGNORE, 1'b1, 1'b1, 8'h00);
		chk("slot_off", n > 500 && n < 1008, 1'b1);
		dq = '{8'h00, `LHFE_SYNCH_CHAR, 8'hC5};
		chk_bus();
		parity_disable_bit = 1'b0;
		mframe(8'h3C, `LHFE_NODE_ACTION_FIELD_IGNORE, 1'b1, 1'b0, 8'h02);
		chk("slot_nochk", n >= 1454 && n <= 1459, 1'b1);
		summarize;
	end
endmodule
